// [include/nfc_map.svh]
// Register offsets, field positions, reset values and constants of the
// flash general configuration block. Definitions only.
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

`define NFC_ADDR_W          12
`define NFC_OFF_SP_THR      12'h034
`define NFC_OFF_SP_CORR     12'h03c
`define NFC_OFF_READY       12'h100
`define NFC_OFF_GENERAL     12'h104
`define NFC_OFF_IRQ_STS     12'h110
`define NFC_OFF_IRQ_CLR     12'h114
`define NFC_OFF_IRQ_EN      12'h118

`define NFC_GEN_CE_LSB      24
`define NFC_GEN_RDYPOS_LSB  12
`define NFC_GEN_PFPOS_LSB   8
`define NFC_GEN_WP_BIT      2
`define NFC_GEN_INV_BIT     1
`define NFC_GEN_SCR_BIT     0

`define NFC_RST_SP_THR      7'h00
`define NFC_RST_SP_CORR     7'h00
`define NFC_RST_READY       1'h1
`define NFC_RST_CE          2'h2
`define NFC_RST_RDYPOS      3'h6
`define NFC_RST_PFPOS       3'h0

`define NFC_EVT_THR_BIT     0
`define NFC_EVT_RDY_BIT     1
`define NFC_EVT_W           2

`define NFC_LFSR_TAPS       16'hb400
`define NFC_LFSR_SEED_ALT   16'h0001
`define NFC_BYTE_ONES       8'hff

`endif

// [include/nfc_pkg.sv]
// Types of the flash general configuration block.
// Relies on nfc_map.svh for the event width and the reset values of spThr, spCorr, flashReady, ceNum, rdyPos and pfPos.
`include "nfc_map.svh"

package nfc_pkg;

    typedef logic [7:0] nfc_byte_t;

    typedef struct packed {
        logic                   pready;
        logic                   pslverr;
        logic [31:0]            prdata;
        logic [6:0]             spThr;
        logic [6:0]             spCorr;
        logic                   flashReady;
        logic [1:0]             ceNum;
        logic [2:0]             rdyPos;
        logic [2:0]             pfPos;
        logic                   wp;
        logic                   inv;
        logic                   scr;
        logic [`NFC_EVT_W-1:0]  irqSts;
        logic [`NFC_EVT_W-1:0]  irqEn;
        logic                   irq;
        logic                   flashWpN;
        logic                   busReady;
        logic                   passFail;
        logic [7:0]             dataOut;
        logic                   dataOutValid;
        logic                   spThrEvt;
    } nfc_state_t;

    typedef struct packed {
        logic [15:0] lfsr;
    } nfc_scr_state_t;

    localparam nfc_state_t NFC_STATE_RST = '{
        pready:       1'b0,
        pslverr:      1'b0,
        prdata:       32'h0000_0000,
        spThr:        `NFC_RST_SP_THR,
        spCorr:       `NFC_RST_SP_CORR,
        flashReady:   `NFC_RST_READY,
        ceNum:        `NFC_RST_CE,
        rdyPos:       `NFC_RST_RDYPOS,
        pfPos:        `NFC_RST_PFPOS,
        wp:           1'b0,
        inv:          1'b0,
        scr:          1'b0,
        irqSts:       2'h0,
        irqEn:        2'h0,
        irq:          1'b0,
        flashWpN:     1'b1,
        busReady:     1'b0,
        passFail:     1'b0,
        dataOut:      8'h00,
        dataOutValid: 1'b0,
        spThrEvt:     1'b0
    };

endpackage

// [hw/nfc_scrambler.sv]
// Data scramble mask generator: 16-bit LFSR, eight steps per byte.
// Assumes seedLoad comes at least one cycle before a sector's first byte.
`timescale 1ns/1ns
`include "nfc_map.svh"

module nfc_scrambler
(
    input  wire logic          clk_sys,
    input  wire logic          resetn,
    input  wire logic          seedLoad,
    input  wire nfc_pkg::nfc_byte_t sectorNum,
    input  wire logic [23:0]   rowAddr,
    input  wire logic          step,
    output      nfc_pkg::nfc_byte_t mask
);
    import nfc_pkg::*;

    nfc_scr_state_t st_ff;
    nfc_scr_state_t nxt_st;
    logic [15:0]    stage [0:8];
    logic [15:0]    seedRaw;
    logic [15:0]    seed;

    // Sector and row fold together so each sector gets its own sequence
    assign seedRaw = {sectorNum, rowAddr[7:0]} ^ rowAddr[23:8];
    // All-zero state would lock the LFSR
    assign seed    = (seedRaw == 16'h0000) ? `NFC_LFSR_SEED_ALT : seedRaw;

    assign stage[0] = st_ff.lfsr;
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_step
            assign stage[i+1] = {stage[i][14:0], ^(stage[i] & `NFC_LFSR_TAPS)};
        end
    endgenerate

    assign mask = st_ff.lfsr[15:8];

    always_comb
    begin
        nxt_st = st_ff;
        if (seedLoad)
        begin
            nxt_st.lfsr = seed;
        end
        else if (step)
        begin
            nxt_st.lfsr = stage[8];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff <= '{lfsr: `NFC_LFSR_SEED_ALT};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    a_seed_load: assert property (@(posedge clk_sys) disable iff (!resetn)
        seedLoad |=> st_ff.lfsr == $past(seed))
        else $error("scrambler seed not loaded");

    a_seed_source: assert property (@(posedge clk_sys) disable iff (!resetn)
        seedLoad && (rowAddr == 24'h000000) |=> st_ff.lfsr[15:8] == $past(sectorNum)
            || $past(sectorNum) == 8'h00)
        else $error("seed ignores sector number");

endmodule

// [hw/nfc_general_config.sv]
// Flash general configuration: spare ECC settings, ready status, general
// settings, status bit pick-off, data invert/scramble and event interrupt.
// Assumes an APB master on clk_sys and flash pins synchronous to clk_sys.
`timescale 1ns/1ns
`include "nfc_map.svh"

module nfc_general_config
(
    input  wire logic                      clk_sys,
    input  wire logic                      resetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`NFC_ADDR_W-1:0]    paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output      logic [31:0]               prdata,
    output      logic                      pready,
    output      logic                      pslverr,
    input  wire logic                      flashReadyIn,
    output      logic                      flashWpN,
    input  wire nfc_pkg::nfc_byte_t        flashBusIn,
    input  wire logic                      statusSample,
    output      logic                      busReadyBit,
    output      logic                      passFailBit,
    output      logic [6:0]                spareErrorThreshold,
    output      logic [6:0]                spareCorrectStrength,
    output      logic [1:0]                ceCount,
    input  wire logic                      spareErrValid,
    input  wire logic [6:0]                spareErrCount,
    output      logic                      spareThresholdEvent,
    input  wire logic                      sectorStart,
    input  wire nfc_pkg::nfc_byte_t        sectorNum,
    input  wire logic [23:0]               rowAddr,
    input  wire logic                      dataValid,
    input  wire logic                      dataIsParity,
    input  wire nfc_pkg::nfc_byte_t        dataIn,
    output      nfc_pkg::nfc_byte_t        dataOut,
    output      logic                      dataOutValid,
    output      logic                      irq
);
    import nfc_pkg::*;

    nfc_state_t     st_ff;
    nfc_state_t     nxt_st;
    nfc_byte_t      scrMask;
    logic           setupPhase;
    logic           wrCommit;
    logic           addrHit;
    logic [31:0]    readWord;
    logic [`NFC_EVT_W-1:0] evtSet;
    logic [`NFC_EVT_W-1:0] evtClr;
    logic           thrHit;
    logic           scrStep;

    nfc_scrambler u_scrambler
    (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .seedLoad  (sectorStart),
        .sectorNum (sectorNum),
        .rowAddr   (rowAddr),
        .step      (scrStep),
        .mask      (scrMask)
    );

    // Parity bytes never advance the mask, so data sequence stays aligned
    assign scrStep    = dataValid && !dataIsParity && !sectorStart;
    assign setupPhase = psel && penable && !st_ff.pready;
    assign wrCommit   = psel && penable && st_ff.pready && pwrite;

    // Count of k erroneous bits reaches threshold field t when k >= t + 1
    assign thrHit = spareErrValid
        && ({1'b0, spareErrCount} >= ({1'b0, st_ff.spThr} + 8'h01));

    always_comb
    begin
        addrHit  = 1'b1;
        readWord = 32'h0000_0000;
        unique case (paddr)
            `NFC_OFF_SP_THR:
            begin
                readWord[6:0] = st_ff.spThr;
            end
            `NFC_OFF_SP_CORR:
            begin
                readWord[6:0] = st_ff.spCorr;
            end
            `NFC_OFF_READY:
            begin
                readWord[0] = st_ff.flashReady;
            end
            `NFC_OFF_GENERAL:
            begin
                readWord[`NFC_GEN_CE_LSB+1:`NFC_GEN_CE_LSB]         = st_ff.ceNum;
                readWord[`NFC_GEN_RDYPOS_LSB+2:`NFC_GEN_RDYPOS_LSB] = st_ff.rdyPos;
                readWord[`NFC_GEN_PFPOS_LSB+2:`NFC_GEN_PFPOS_LSB]   = st_ff.pfPos;
                readWord[`NFC_GEN_WP_BIT]                           = st_ff.wp;
                readWord[`NFC_GEN_INV_BIT]                          = st_ff.inv;
                readWord[`NFC_GEN_SCR_BIT]                          = st_ff.scr;
            end
            `NFC_OFF_IRQ_STS:
            begin
                readWord[`NFC_EVT_W-1:0] = st_ff.irqSts;
            end
            `NFC_OFF_IRQ_EN:
            begin
                readWord[`NFC_EVT_W-1:0] = st_ff.irqEn;
            end
            `NFC_OFF_IRQ_CLR:
            begin
                readWord = 32'h0000_0000;
            end
            default:
            begin
                addrHit = 1'b0;
            end
        endcase
    end

    always_comb
    begin
        nxt_st = st_ff;
        evtSet = '0;
        evtClr = '0;

        // One wait state: answer and read data are both registered
        nxt_st.pready  = setupPhase;
        nxt_st.pslverr = setupPhase && !addrHit;
        if (setupPhase)
        begin
            nxt_st.prdata = pwrite ? 32'h0000_0000 : readWord;
        end

        if (wrCommit)
        begin
            unique case (paddr)
                `NFC_OFF_SP_THR:
                begin
                    if (pstrb[0])
                    begin
                        nxt_st.spThr = pwdata[6:0];
                    end
                end
                `NFC_OFF_SP_CORR:
                begin
                    if (pstrb[0])
                    begin
                        nxt_st.spCorr = pwdata[6:0];
                    end
                end
                `NFC_OFF_GENERAL:
                begin
                    if (pstrb[3])
                    begin
                        nxt_st.ceNum = pwdata[`NFC_GEN_CE_LSB+1:`NFC_GEN_CE_LSB];
                    end
                    if (pstrb[1])
                    begin
                        nxt_st.rdyPos = pwdata[`NFC_GEN_RDYPOS_LSB+2:`NFC_GEN_RDYPOS_LSB];
                        nxt_st.pfPos  = pwdata[`NFC_GEN_PFPOS_LSB+2:`NFC_GEN_PFPOS_LSB];
                    end
                    if (pstrb[0])
                    begin
                        nxt_st.wp  = pwdata[`NFC_GEN_WP_BIT];
                        nxt_st.inv = pwdata[`NFC_GEN_INV_BIT];
                        nxt_st.scr = pwdata[`NFC_GEN_SCR_BIT];
                    end
                end
                `NFC_OFF_IRQ_CLR:
                begin
                    if (pstrb[0])
                    begin
                        evtClr = pwdata[`NFC_EVT_W-1:0];
                    end
                end
                `NFC_OFF_IRQ_EN:
                begin
                    if (pstrb[0])
                    begin
                        nxt_st.irqEn = pwdata[`NFC_EVT_W-1:0];
                    end
                end
                default:
                begin
                    nxt_st.irqEn = st_ff.irqEn;
                end
            endcase
        end

        // Ready line is synchronous, so one register is enough
        nxt_st.flashReady = flashReadyIn;
        nxt_st.flashWpN   = !nxt_st.wp;

        if (statusSample)
        begin
            nxt_st.busReady = flashBusIn[st_ff.rdyPos];
            nxt_st.passFail = flashBusIn[st_ff.pfPos];
        end

        // Same XOR serves write and read, so the path is its own inverse
        nxt_st.dataOutValid = dataValid;
        if (dataValid)
        begin
            nxt_st.dataOut = dataIn
                ^ (st_ff.inv ? `NFC_BYTE_ONES : 8'h00)
                ^ ((st_ff.scr && !dataIsParity) ? scrMask : 8'h00);
        end

        nxt_st.spThrEvt = thrHit;
        evtSet[`NFC_EVT_THR_BIT] = thrHit;
        evtSet[`NFC_EVT_RDY_BIT] = flashReadyIn && !st_ff.flashReady;
        // Set beats clear when both land together
        nxt_st.irqSts = (st_ff.irqSts & ~evtClr) | evtSet;
        nxt_st.irq    = |(nxt_st.irqSts & nxt_st.irqEn);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_ff <= NFC_STATE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign prdata               = st_ff.prdata;
    assign pready               = st_ff.pready;
    assign pslverr              = st_ff.pslverr;
    assign flashWpN             = st_ff.flashWpN;
    assign busReadyBit          = st_ff.busReady;
    assign passFailBit          = st_ff.passFail;
    assign spareErrorThreshold  = st_ff.spThr;
    assign spareCorrectStrength = st_ff.spCorr;
    assign ceCount              = st_ff.ceNum;
    assign spareThresholdEvent  = st_ff.spThrEvt;
    assign dataOut              = st_ff.dataOut;
    assign dataOutValid         = st_ff.dataOutValid;
    assign irq                  = st_ff.irq;

    sequence s_wr_commit(logic [`NFC_ADDR_W-1:0] a);
        psel && penable && pready && pwrite && paddr == a && pstrb == 4'hf;
    endsequence

    sequence s_rd_start(logic [`NFC_ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    a_thr_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_wr_commit(`NFC_OFF_SP_THR) |=> spareErrorThreshold == $past(pwdata[6:0]))
        else $error("spare threshold not written");

    a_corr_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_wr_commit(`NFC_OFF_SP_CORR) |=> spareCorrectStrength == $past(pwdata[6:0]))
        else $error("spare correction not written");

    a_ready_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(pready) && !pwrite && paddr == `NFC_OFF_READY
        |-> prdata[0] == $past(flashReadyIn, 2))
        else $error("ready bit does not mirror pin");

    a_ce_write: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_wr_commit(`NFC_OFF_GENERAL) |=> ceCount == $past(pwdata[25:24]))
        else $error("chip enable count not written");

    a_status_pick: assert property (@(posedge clk_sys) disable iff (!resetn)
        statusSample |=> busReadyBit == $past(flashBusIn[st_ff.rdyPos])
            && passFailBit == $past(flashBusIn[st_ff.pfPos]))
        else $error("status bit taken from wrong lane");

    a_wp_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_wr_commit(`NFC_OFF_GENERAL) |=> flashWpN == !$past(pwdata[2]))
        else $error("write protect pin wrong");

    a_erased_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        dataValid && st_ff.inv && !st_ff.scr && dataIn == 8'hff |=> dataOutValid && dataOut == 8'h00)
        else $error("erased byte not zero after inversion");

    a_parity_plain: assert property (@(posedge clk_sys) disable iff (!resetn)
        dataValid && dataIsParity |=> dataOut == ($past(dataIn) ^ {8{$past(st_ff.inv)}}))
        else $error("parity byte scrambled");

    // Set beats clear, so the status bit is up on the same edge as the pulse
    a_thr_event: assert property (@(posedge clk_sys) disable iff (!resetn)
        spareErrValid && spareErrCount > spareErrorThreshold
        |=> spareThresholdEvent && st_ff.irqSts[`NFC_EVT_THR_BIT])
        else $error("threshold event missing");

    a_apb_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_rd_start(`NFC_OFF_GENERAL) ##1 (psel && penable) |=> pready && !pslverr)
        else $error("register read not answered");

endmodule

// [verification/nfc_flash_model.sv]
// Flash device seen from the pins: ready line and status byte on the bus.
// Assumes the bench pulses opStart and says when the device drives the bus.
`timescale 1ns/1ns

module nfc_flash_model #(parameter int BUSY_CYC = 20)
(
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               opStart,
    input  wire logic               busOe,
    input  wire nfc_pkg::nfc_byte_t statusIn,
    output      logic               flashReadyIn,
    output      nfc_pkg::nfc_byte_t flashBusIn
);
    import nfc_pkg::*;
    int        busyCnt;
    nfc_byte_t lastByte;
    assign flashReadyIn = (busyCnt == 0);
    // Released bus shows no stale byte
    assign flashBusIn = busOe ? statusIn : ~lastByte;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            busyCnt  <= 0;
            lastByte <= 8'h00;
        end
        else
        begin
            if (opStart)
                busyCnt <= BUSY_CYC;
            else if (busyCnt != 0)
                busyCnt <= busyCnt - 1;
            if (busOe)
                lastByte <= statusIn;
        end
    end
endmodule

// [verification/tb.sv]
// Self-checking bench of the flash general configuration block.
// Assumes an APB master and the flash model on the pins, one clock.
`timescale 1ns/1ns
`include "nfc_map.svh"

module tb;
    import nfc_pkg::*;
    logic        clk_sys = 1'b0, resetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, flashReadyIn, flashWpN, busReadyBit, passFailBit;
    logic        statusSample = 1'b0, spareErrValid = 1'b0, sectorStart = 1'b0;
    logic        dataValid = 1'b0, dataIsParity = 1'b0, opStart = 1'b0, busOe = 1'b0;
    logic [6:0]  spareErrorThreshold, spareCorrectStrength, spareErrCount = 7'h00;
    logic [1:0]  ceCount;
    logic        spareThresholdEvent, dataOutValid, irq;
    nfc_byte_t   flashBusIn, dataOut, statusIn = 8'h00, sectorNum = 8'h00, dataIn = 8'h00;
    logic [23:0] rowAddr = 24'h0;
    int          err_count = 0, samples_checked = 0, cyc = 0;

    nfc_general_config u_dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .flashReadyIn, .flashWpN, .flashBusIn,
        .statusSample, .busReadyBit, .passFailBit, .spareErrorThreshold, .spareCorrectStrength,
        .ceCount, .spareErrValid, .spareErrCount, .spareThresholdEvent, .sectorStart,
        .sectorNum, .rowAddr, .dataValid, .dataIsParity, .dataIn, .dataOut, .dataOutValid, .irq);
    nfc_flash_model u_flash (.clk_sys, .resetn, .opStart, .busOe, .statusIn, .flashReadyIn,
        .flashBusIn);

    initial forever #5 clk_sys = ~clk_sys;

    task automatic print_verdict;
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Generous: whole run is a few hundred cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
        end
    endtask

    // Slave latency is not assumed: only the global timeout ends the wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_reg(r, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic t_reset;
        rdc(`NFC_OFF_SP_THR, 32'h0);
        rdc(`NFC_OFF_SP_CORR, 32'h0);
        rdc(`NFC_OFF_READY, 32'h1);
        rdc(`NFC_OFF_GENERAL, 32'h0200_6000);
        chk_pin(32'(flashWpN), 32'h1);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        wr(`NFC_OFF_SP_THR, 32'hffff_ffff);
        rdc(`NFC_OFF_SP_THR, 32'h7f);
        wr(`NFC_OFF_SP_CORR, 32'h0000_000f);
        rdc(`NFC_OFF_SP_CORR, 32'h0f);
        chk_pin(32'(spareErrorThreshold), 32'h7f);
        chk_pin(32'(spareCorrectStrength), 32'h0f);
        wr(`NFC_OFF_GENERAL, 32'hffff_fff8);
        rdc(`NFC_OFF_GENERAL, 32'h0300_7700);
        // Power-of-two device counts only, every code once
        for (int c = 0; c < 4; c++)
        begin
            wr(`NFC_OFF_GENERAL, 32'(c) << 24);
            settle();
            chk_pin(32'(ceCount), 32'(c));
        end
        // Lane 1 only: position fields move, chip-enable count stays
        @(posedge clk_sys);
        pstrb <= 4'h2;
        wr(`NFC_OFF_GENERAL, 32'h0000_5300);
        pstrb <= 4'hf;
        rdc(`NFC_OFF_GENERAL, 32'h0300_5300);
        wr(`NFC_OFF_READY, 32'h0);
        rdc(`NFC_OFF_READY, 32'h1);
        apb(1'b0, 12'h200, 32'h0, r, e);
        chk_reg(32'(e), 32'h1);
    endtask

    task automatic t_wp;
        wr(`NFC_OFF_GENERAL, 32'h4);
        settle();
        chk_pin(32'(flashWpN), 32'h0);
        wr(`NFC_OFF_GENERAL, 32'h0);
        settle();
        chk_pin(32'(flashWpN), 32'h1);
    endtask

    task automatic t_ready;
        wr(`NFC_OFF_IRQ_CLR, 32'h3);
        @(posedge clk_sys);
        opStart <= 1'b1;
        @(posedge clk_sys);
        opStart <= 1'b0;
        rdc(`NFC_OFF_READY, 32'h0);
        // A stuck busy line is caught by the global timeout
        while (flashReadyIn !== 1'b1)
        begin
            @(posedge clk_sys);
        end
        rdc(`NFC_OFF_READY, 32'h1);
        rdc(`NFC_OFF_IRQ_STS, 32'h2);
    endtask

    task automatic samp(input nfc_byte_t b, input logic er, input logic ep);
        @(posedge clk_sys);
        busOe        <= 1'b1;
        statusIn     <= b;
        statusSample <= 1'b1;
        @(posedge clk_sys);
        statusSample <= 1'b0;
        busOe        <= 1'b0;
        @(negedge clk_sys);
        chk_pin(32'(busReadyBit), 32'(er));
        chk_pin(32'(passFailBit), 32'(ep));
    endtask

    task automatic t_status;
        for (int p = 0; p < 8; p++)
        begin
            wr(`NFC_OFF_GENERAL, (32'(p) << 12) | (32'((p + 3) % 8) << 8));
            samp(8'h01 << p, 1'b1, 1'b0);
            samp(8'h01 << ((p + 3) % 8), 1'b0, 1'b1);
        end
    endtask

    task automatic xfer(input logic par, input nfc_byte_t d, input nfc_byte_t exp);
        @(posedge clk_sys);
        dataValid    <= 1'b1;
        dataIsParity <= par;
        dataIn       <= d;
        @(posedge clk_sys);
        dataValid <= 1'b0;
        @(negedge clk_sys);
        chk_pin(32'(dataOutValid), 32'h1);
        chk_pin(32'(dataOut), 32'(exp));
    endtask

    function automatic logic [15:0] adv(input logic [15:0] s);
        for (int i = 0; i < 8; i++)
            s = {s[14:0], ^(s & `NFC_LFSR_TAPS)};
        return s;
    endfunction

    task automatic t_data;
        logic [15:0] s;
        wr(`NFC_OFF_GENERAL, 32'h2);
        xfer(1'b0, 8'hff, 8'h00);
        xfer(1'b1, 8'hff, 8'h00);
        xfer(1'b0, 8'h5a, 8'ha5);
        wr(`NFC_OFF_GENERAL, 32'h1);
        @(posedge clk_sys);
        sectorNum   <= 8'h3c;
        rowAddr     <= 24'h12_3456;
        sectorStart <= 1'b1;
        @(posedge clk_sys);
        sectorStart <= 1'b0;
        s = {8'h3c, 8'h56} ^ 16'h1234;
        xfer(1'b0, 8'h00, s[15:8]);
        s = adv(s);
        xfer(1'b0, 8'h0f, s[15:8] ^ 8'h0f);
        xfer(1'b1, 8'h77, 8'h77);
        s = adv(s);
        xfer(1'b0, 8'h00, s[15:8]);
        // Row zero: the sector number alone fills the upper seed byte
        @(posedge clk_sys);
        sectorNum   <= 8'h81;
        rowAddr     <= 24'h00_0000;
        sectorStart <= 1'b1;
        @(posedge clk_sys);
        sectorStart <= 1'b0;
        xfer(1'b0, 8'h00, 8'h81);
    endtask

    task automatic evt(input logic [6:0] c, input logic e);
        @(posedge clk_sys);
        spareErrValid <= 1'b1;
        spareErrCount <= c;
        @(posedge clk_sys);
        spareErrValid <= 1'b0;
        @(negedge clk_sys);
        chk_pin(32'(spareThresholdEvent), 32'(e));
    endtask

    task automatic t_thr;
        wr(`NFC_OFF_SP_THR, 32'h4);
        wr(`NFC_OFF_IRQ_CLR, 32'h3);
        wr(`NFC_OFF_IRQ_EN, 32'h1);
        evt(7'd4, 1'b0);
        evt(7'd5, 1'b1);
        settle();
        chk_pin(32'(irq), 32'h1);
        rdc(`NFC_OFF_IRQ_STS, 32'h1);
        wr(`NFC_OFF_IRQ_CLR, 32'h1);
        settle();
        chk_pin(32'(irq), 32'h0);
        rdc(`NFC_OFF_IRQ_STS, 32'h0);
        wr(`NFC_OFF_IRQ_EN, 32'h0);
        evt(7'd16, 1'b1);
        settle();
        chk_pin(32'(irq), 32'h0);
        rdc(`NFC_OFF_IRQ_STS, 32'h1);
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_wp();
        t_ready();
        t_status();
        t_data();
        t_thr();
        print_verdict();
    end
endmodule
